// ### homing_pkg.sv
// constants, register map and state codes for the axis homing sequencer
package homing_pkg;
    localparam int NAX = 5;
    localparam int DW  = 32;
    // ---------------------------------------------------------------
    // register map: group in paddr[7:5], word in paddr[4:2]
    // ---------------------------------------------------------------
    localparam logic [2:0] G_SCAL = 3'h0;
    localparam logic [2:0] G_VHI  = 3'h1;
    localparam logic [2:0] G_VLO  = 3'h2;
    localparam logic [2:0] G_TURN = 3'h3;
    localparam logic [2:0] G_PLIM = 3'h4;
    localparam logic [2:0] G_NLIM = 3'h5;
    localparam logic [2:0] G_ZERO = 3'h6;
    localparam logic [2:0] W_CFG   = 3'h0;
    localparam logic [2:0] W_CMD   = 3'h1;
    localparam logic [2:0] W_STAT  = 3'h2;
    localparam logic [2:0] W_GEAR  = 3'h3;
    localparam logic [2:0] W_VSLOW = 3'h4;
    localparam logic [2:0] W_VRET  = 3'h5;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int C_BUS  = 0;
    localparam int C_HS   = 1;
    localparam int C_IDX  = 2;
    localparam int C_MB   = 3;
    localparam int C_ABS  = 4;
    localparam int C_MT   = 5;
    localparam int C_MAN  = 6;
    localparam int C_LIM  = 7;
    localparam int C_DIR  = 8;
    localparam int C_GRAT = 16;
    localparam int K_AXIS = 0;
    localparam int K_GO   = 4;
    localparam int K_ABRT = 5;
    localparam int K_SETZ = 8;
    localparam int GR_RAT = 0;
    localparam int GR_FDR = 16;
    localparam int ST_BSY = 8;
    localparam int ST_LIM = 16;
    localparam int ST_STA = 24;
    localparam int TURN_W = 16;
    localparam logic [DW-1:0] RST_CFG = 32'h0000_0001;
    localparam logic signed [DW-1:0] LIM_MAX = 32'sh3B9A_C9FF;
    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_FAST  = 8'h02,
        S_LOW   = 8'h04,
        S_SLOW  = 8'h08,
        S_HSEEK = 8'h10,
        S_HSTOP = 8'h20,
        S_RET   = 8'h40,
        S_STOP  = 8'h80
    } hstate_t;
endpackage

// ### sync_flops.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync_flops #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            dout   <= '0;
        end else if (ce) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // sync_flops

// ### axis_homing_sequencer.sv
// per-axis machine zero sequencer with apb registers
// Operation
// R1 - common return, index or no index
// R2 - high-speed return requires index pulse
// R3 - direction from per-axis direction bit
// R4 - fast velocity until slowdown switch
// R5 - high-speed: low velocity, seek index
// R6 - high-speed: stop at index, return
// R7 - common: very slow seek, immediate stop
// R8 - light indicator when stopped at zero
// R9 - clear indicator when off zero
// R10 - absolute turn offset replaces index
// R11 - multi-turn set needs all encoder bits
// R12 - set-zero bit captures absolute position
// R13 - absolute zero survives restart
// R14 - soft limits only when enabled, clamped
// R15 - per-axis grating fitted setting held
// R16 - direction or gear change loses zero
// R17 - operator resets other reference points
// R18 - no homing without switch or zero
// R19 - each axis supplies slowdown input
// R20 - no index: method select picks B/A
// R21 - parameters frozen during a sequence
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module axis_homing_sequencer
    import homing_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [DW-1:0]           pwdata,
    output logic      [DW-1:0]           prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    axis_x_slowdown_input,
    input  wire logic                    axis_y_slowdown_input,
    input  wire logic                    axis_z_slowdown_input,
    input  wire logic                    axis_four_slowdown_input,
    input  wire logic                    axis_five_slowdown_input,
    input  wire logic [NAX-1:0]          indexPulse,
    input  wire logic [NAX-1:0]          axisStopped,
    input  wire logic [NAX-1:0][DW-1:0]  axisPos,
    input  wire logic [NAX-1:0]          nvZeroValid,
    input  wire logic [NAX-1:0][DW-1:0]  nvZeroPos,
    output logic      [NAX-1:0]          axisMove,
    output logic                         moveNeg,
    output logic      [DW-1:0]           velCmd,
    output logic      [NAX-1:0]          zeroInd,
    output logic      [NAX-1:0]          zeroValid,
    output logic      [NAX-1:0][DW-1:0]  zeroPosOut,
    output logic      [NAX-1:0]          limitHit
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [DW-1:0] clampLim(input logic [DW-1:0] v);
        logic signed [DW-1:0] s;
        s = v;
        if (s > LIM_MAX)
            clampLim = LIM_MAX;
        else if (s < -LIM_MAX)
            clampLim = -LIM_MAX;
        else
            clampLim = v;
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [NAX-1:0] slowS, idxS, stopS, idxPrev_q;
    logic [NAX-1:0] slowRaw;
    assign slowRaw = {axis_five_slowdown_input, axis_four_slowdown_input,
                      axis_z_slowdown_input, axis_y_slowdown_input,
                      axis_x_slowdown_input}; // R19
    sync_flops #(.W(3*NAX)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .din     ({stopS_raw(axisStopped), indexPulse, slowRaw}),
        .dout    ({stopS, idxS, slowS})
    );
    function automatic logic [NAX-1:0] stopS_raw(input logic [NAX-1:0] v);
        stopS_raw = v;
    endfunction

    // -----------------------------------------------------------------
    // apb slave: one wait state, effect at the completing edge
    // -----------------------------------------------------------------
    logic [DW-1:0] cfg_q, gear_q, vSlow_q, vRet_q, rd;
    logic [DW-1:0] vHiR_q [NAX], vLoR_q [NAX], turnR_q [NAX];
    logic [DW-1:0] pLim_q [NAX], nLim_q [NAX];
    logic [NAX-1:0][DW-1:0] zeroPos_q;
    logic [NAX-1:0] absValid_q, homed_q, lost;
    logic [2:0] grp, wrd;
    logic       acc, wrEn, bad, go, abrt, mtEn;
    hstate_t    state_q, state_d;
    assign grp  = paddr[7:5];
    assign wrd  = paddr[4:2];
    assign acc  = psel & penable & ~pready;
    assign wrEn = psel & penable & pready & pwrite;
    assign mtEn = cfg_q[C_BUS] & cfg_q[C_ABS] & cfg_q[C_MT]
                & cfg_q[C_MAN]; // R11
    assign go   = wrEn && grp == G_SCAL && wrd == W_CMD && pwdata[K_GO];
    assign abrt = wrEn && grp == G_SCAL && wrd == W_CMD && pwdata[K_ABRT];

    always_comb begin
        rd  = '0;
        bad = 1'b0;
        if (grp == G_SCAL) begin
            case (wrd)
                W_CFG:   rd = cfg_q;
                W_CMD:   rd = '0;
                W_STAT:  rd = {state_q, 3'h0, limitHit, 7'h0, state_q != S_IDLE,
                               3'h0, zeroInd};
                W_GEAR:  rd = gear_q;
                W_VSLOW: rd = vSlow_q;
                W_VRET:  rd = vRet_q;
                default: bad = 1'b1;
            endcase
        end else if (wrd >= 3'(NAX) || grp == 3'h7) begin
            bad = 1'b1;
        end else begin
            case (grp)
                G_VHI:   rd = vHiR_q[wrd];
                G_VLO:   rd = vLoR_q[wrd];
                G_TURN:  rd = turnR_q[wrd];
                G_PLIM:  rd = pLim_q[wrd];
                G_NLIM:  rd = nLim_q[wrd];
                default: rd = zeroPos_q[wrd];
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready  <= acc;
            pslverr <= acc & bad;
            prdata  <= (acc && !pwrite) ? rd : '0;
        end
    end

    // -----------------------------------------------------------------
    // configuration writes; frozen copies only change when idle
    // -----------------------------------------------------------------
    always_comb begin
        lost = '0;
        if (wrEn && grp == G_SCAL && wrd == W_CFG)
            lost = cfg_q[C_DIR +: NAX] ^ pwdata[C_DIR +: NAX]; // R16
        if (wrEn && grp == G_SCAL && wrd == W_GEAR) begin
            lost = gear_q[GR_FDR +: NAX] ^ pwdata[GR_FDR +: NAX];
            if (gear_q[GR_RAT +: 16] != pwdata[GR_RAT +: 16])
                lost = '1; // R16
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q   <= RST_CFG;
            gear_q  <= '0;
            vSlow_q <= '0;
            vRet_q  <= '0;
            for (int i = 0; i < NAX; i++) begin
                vHiR_q[i]  <= '0;
                vLoR_q[i]  <= '0;
                turnR_q[i] <= '0;
                pLim_q[i]  <= '0;
                nLim_q[i]  <= '0;
            end
        end else if (ce && wrEn && !bad) begin
            case (grp)
                G_SCAL: begin
                    if (wrd == W_CFG)
                        cfg_q <= pwdata; // R15
                    if (wrd == W_GEAR)
                        gear_q <= pwdata;
                    if (wrd == W_VSLOW)
                        vSlow_q <= pwdata;
                    if (wrd == W_VRET)
                        vRet_q <= pwdata;
                end
                G_VHI:   vHiR_q[wrd]  <= pwdata;
                G_VLO:   vLoR_q[wrd]  <= pwdata;
                G_TURN:  turnR_q[wrd] <= pwdata; // R10
                G_PLIM:  pLim_q[wrd]  <= clampLim(pwdata); // R14
                G_NLIM:  nLim_q[wrd]  <= clampLim(pwdata); // R14
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // sequence capture of axis and parameters
    // -----------------------------------------------------------------
    logic [2:0]    ax_q;
    logic          hs_q, idx_q, mb_q, neg_q, absT_q;
    logic [DW-1:0] vHi_q, vLo_q, vS_q, vR_q, turn_q, idxPos_q;
    logic [2:0]    axW;
    logic          start, sd, ix, ixRise, st;
    assign axW   = pwdata[K_AXIS +: 3];
    // high-speed mode refuses a start without the index method
    assign start = go && cfg_q[C_BUS] && axW < 3'(NAX)
                && (!cfg_q[C_HS] || cfg_q[C_IDX]); // R1 R2
    assign sd    = slowS[ax_q];
    assign st    = stopS[ax_q];
    assign ix    = absT_q ? (axisPos[ax_q][TURN_W-1:0] == turn_q[TURN_W-1:0])
                          : idxS[ax_q]; // R10
    assign ixRise = ix & ~idxPrev_q[ax_q];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ax_q   <= '0;
            hs_q   <= 1'b0;
            idx_q  <= 1'b0;
            mb_q   <= 1'b0;
            neg_q  <= 1'b0;
            absT_q <= 1'b0;
            vHi_q  <= '0;
            vLo_q  <= '0;
            vS_q   <= '0;
            vR_q   <= '0;
            turn_q <= '0;
        end else if (ce && state_q == S_IDLE && start) begin
            ax_q   <= axW; // R21
            hs_q   <= cfg_q[C_HS];
            idx_q  <= cfg_q[C_IDX];
            mb_q   <= cfg_q[C_MB]; // R20
            neg_q  <= cfg_q[C_DIR + int'(axW)]; // R3
            absT_q <= cfg_q[C_HS] & cfg_q[C_ABS]; // R10
            vHi_q  <= vHiR_q[axW];
            vLo_q  <= vLoR_q[axW];
            vS_q   <= vSlow_q;
            vR_q   <= vRet_q;
            turn_q <= turnR_q[axW];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idxPrev_q <= '0;
            idxPos_q  <= '0;
        end else if (ce) begin
            idxPrev_q <= idxS;
            // the active axis remembers its own index source, pin or turn match
            idxPrev_q[ax_q] <= ix;
            if (state_q == S_HSEEK && ixRise)
                idxPos_q <= axisPos[ax_q]; // R6
        end
    end

    // -----------------------------------------------------------------
    // homing state machine
    // -----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE:  if (start) state_d = S_FAST;
            S_FAST:  if (sd) state_d = S_LOW; // R4
            S_LOW: begin
                if (!sd) begin
                    if (hs_q)
                        state_d = S_HSEEK; // R5
                    else if (idx_q || mb_q)
                        state_d = S_SLOW; // R7 R20
                    else
                        state_d = S_STOP; // R20
                end
            end
            S_SLOW: begin
                if (idx_q ? ixRise : sd)
                    state_d = S_STOP; // R7 R20
            end
            S_HSEEK: if (ixRise) state_d = S_HSTOP; // R5
            S_HSTOP: if (st) state_d = S_RET; // R6
            S_RET:   if (axisPos[ax_q] == idxPos_q) state_d = S_STOP; // R6
            S_STOP:  if (st) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
        if (abrt && state_q != S_IDLE && state_q != S_STOP)
            state_d = S_STOP;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            state_q <= S_IDLE;
        else if (ce)
            state_q <= state_d;
    end

    // motion command follows the next state so it is registered
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            axisMove <= '0;
            moveNeg  <= 1'b0;
            velCmd   <= '0;
        end else if (ce) begin
            axisMove <= '0;
            moveNeg  <= neg_q; // R3
            velCmd   <= '0;
            case (state_d)
                S_FAST: begin
                    // on the start edge the captured copies are not loaded yet
                    velCmd  <= state_q == S_IDLE ? vHiR_q[axW] : vHi_q; // R4
                    moveNeg <= state_q == S_IDLE ? cfg_q[C_DIR + int'(axW)] : neg_q; // R3
                end
                S_LOW:   velCmd <= vLo_q; // R5
                S_HSEEK: velCmd <= vLo_q; // R5
                S_SLOW:  velCmd <= mb_q && !idx_q ? vLo_q : vS_q; // R7
                S_RET: begin
                    velCmd  <= vR_q; // R6
                    moveNeg <= ~neg_q;
                end
                default: velCmd <= '0;
            endcase
            if (state_d inside {S_FAST, S_LOW, S_HSEEK, S_SLOW, S_RET})
                axisMove <= NAX'(1) << (state_q == S_IDLE ? axW : ax_q);
        end
    end

    // -----------------------------------------------------------------
    // zero state: incremental homed flags and absolute zero record
    // -----------------------------------------------------------------
    logic boot_q;
    logic [NAX-1:0] setz, homed_d, absValid_d, ind_d, lim_d;
    logic signed [DW-1:0] rel [NAX];
    assign setz = (wrEn && grp == G_SCAL && wrd == W_CMD && mtEn)
                ? pwdata[K_SETZ +: NAX] : '0; // R11 R12

    always_comb begin
        homed_d    = homed_q;
        absValid_d = absValid_q & ~lost; // R16
        for (int i = 0; i < NAX; i++) begin
            if (stopS[i] == 1'b0 && !(state_q != S_IDLE && ax_q == 3'(i)))
                homed_d[i] = 1'b0; // R9
            if (lost[i])
                homed_d[i] = 1'b0; // R16
            rel[i] = axisPos[i] - zeroPos_q[i];
            lim_d[i] = cfg_q[C_LIM] && (rel[i] > $signed(pLim_q[i])
                    || rel[i] < $signed(nLim_q[i])); // R14
        end
        if (state_q == S_STOP && st && !abrt)
            homed_d[ax_q] = 1'b1; // R8
        absValid_d = absValid_d | setz; // R12
        for (int i = 0; i < NAX; i++)
            ind_d[i] = mtEn ? absValid_d[i] && (setz[i]
                     || axisPos[i] == zeroPos_q[i]) : homed_d[i]; // R8 R9
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            boot_q     <= 1'b0;
            homed_q    <= '0;
            absValid_q <= '0;
            zeroPos_q  <= '0;
            zeroInd    <= '0;
            limitHit   <= '0;
        end else if (ce) begin
            boot_q   <= 1'b1;
            homed_q  <= homed_d;
            zeroInd  <= boot_q ? ind_d : '0;
            limitHit <= lim_d;
            if (!boot_q) begin
                absValid_q <= nvZeroValid; // R13
                zeroPos_q  <= nvZeroPos;
            end else begin
                absValid_q <= absValid_d;
                for (int i = 0; i < NAX; i++)
                    if (setz[i])
                        zeroPos_q[i] <= axisPos[i]; // R12
            end
        end
    end
    assign zeroValid  = absValid_q;
    assign zeroPosOut = zeroPos_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst || !ce);
    sequence sHsFound;
        state_q == S_HSEEK && ixRise ##1 state_q == S_HSTOP;
    endsequence
    a_fast_velocity: assert property (state_q == S_FAST |-> velCmd == vHi_q
        && axisMove[ax_q]) else $error("fast velocity wrong"); // R4
    a_seek_low_vel: assert property (state_q == S_HSEEK |-> velCmd == vLo_q)
        else $error("seek velocity wrong"); // R5
    a_index_stops: assert property (sHsFound |-> velCmd == '0
        && axisMove == '0) else $error("no stop at index"); // R6
    a_return_reverse: assert property (state_q == S_RET |-> velCmd == vR_q
        && moveNeg == !neg_q) else $error("return move wrong"); // R6
    a_common_slow: assert property (state_q == S_SLOW && idx_q |-> velCmd == vS_q)
        else $error("slow search velocity wrong"); // R7
    a_done_lights: assert property (state_q == S_STOP && st && !abrt && !mtEn
        |=> zeroInd[$past(ax_q)]) else $error("indicator not lit"); // R8
    a_hs_refused: assert property (state_q == S_IDLE && go && cfg_q[C_HS]
        && !cfg_q[C_IDX] |=> state_q == S_IDLE) else $error("start taken"); // R2
    a_setz_capture: assert property (boot_q && setz[0] |=> absValid_q[0]
        && zeroPos_q[0] == $past(axisPos[0])) else $error("zero not kept"); // R12
    a_limit_gated: assert property (!cfg_q[C_LIM] |=> limitHit == '0)
        else $error("limit while disabled"); // R14
    a_params_frozen: assert property (state_q != S_IDLE |=> $stable(vHi_q)
        && $stable(ax_q)) else $error("parameters changed"); // R21
endmodule // axis_homing_sequencer

// ### drive_model.sv
// behavioural drives, encoders and slowdown switches for five axes
`timescale 1ns/1ns
module drive_model
    import homing_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic [NAX-1:0]         axisMove,
    input  wire logic                   moveNeg,
    input  wire logic [DW-1:0]          velCmd,
    output logic      [NAX-1:0]         slowSw,
    output logic      [NAX-1:0]         indexPulse,
    output logic      [NAX-1:0]         axisStopped,
    output logic      [NAX-1:0][DW-1:0] axisPos
);
    // -----------------------------------------------------------
    // one count per cycle; the axis halts at once on a zero command
    // -----------------------------------------------------------
    localparam int SW_LO = 40;
    localparam int SW_HI = 60;
    always_ff @(posedge sys_clk or negedge nrst) begin
        for (int i = 0; i < NAX; i++) begin
            if (!nrst) begin
                axisPos[i] <= 32'h0000_0064;
            end else if (axisMove[i] && velCmd != '0) begin
                axisPos[i] <= moveNeg ? axisPos[i] - 1 : axisPos[i] + 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NAX; i++) begin
            axisStopped[i] = !(axisMove[i] && velCmd != '0);
            slowSw[i] = $signed(axisPos[i]) >= SW_LO && $signed(axisPos[i]) <= SW_HI;
            indexPulse[i] = axisPos[i][3:0] == 4'h0;
        end
    end
endmodule // drive_model

// ### tb_top.sv
// self-checking bench for the axis homing sequencer
`timescale 1ns/1ns
module tb_top
    import homing_pkg::*;
;
    typedef struct packed {
        logic [7:0] a; logic [DW-1:0] w; logic wr; logic [DW-1:0] e; logic er;
    } row_t;
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, moveNeg;
    logic [7:0] paddr;
    logic [DW-1:0] pwdata, prdata, velCmd, rd;
    logic [NAX-1:0] slowSw, indexPulse, axisStopped, axisMove, zeroInd, zeroValid;
    logic [NAX-1:0] limitHit, nvZeroValid;
    logic [NAX-1:0][DW-1:0] axisPos, nvZeroPos, zeroPosOut;
    logic er;
    int errors, numChecks;
    row_t rows[11] = '{
        '{8'h00, 32'h0, 1'b0, RST_CFG, 1'b0}, '{8'h20, 32'h10, 1'b1, 32'h10, 1'b0},
        '{8'h40, 32'h08, 1'b1, 32'h08, 1'b0}, '{8'h24, 32'h10, 1'b1, 32'h10, 1'b0},
        '{8'h44, 32'h08, 1'b1, 32'h08, 1'b0}, '{8'h10, 32'h02, 1'b1, 32'h02, 1'b0},
        '{8'h14, 32'h03, 1'b1, 32'h03, 1'b0}, '{8'h80, 32'h7FFF_FFFF, 1'b1, LIM_MAX, 1'b0},
        '{8'hA0, 32'h8000_0000, 1'b1, 32'hC465_3601, 1'b0},
        '{8'hE0, 32'h5, 1'b1, 32'h0, 1'b1}, '{8'h34, 32'h5, 1'b1, 32'h0, 1'b1}};

    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end

    axis_homing_sequencer uut (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .axis_x_slowdown_input(slowSw[0]),
        .axis_y_slowdown_input(slowSw[1]), .axis_z_slowdown_input(slowSw[2]),
        .axis_four_slowdown_input(slowSw[3]), .axis_five_slowdown_input(slowSw[4]),
        .indexPulse(indexPulse), .axisStopped(axisStopped), .axisPos(axisPos),
        .nvZeroValid(nvZeroValid), .nvZeroPos(nvZeroPos), .axisMove(axisMove),
        .moveNeg(moveNeg), .velCmd(velCmd), .zeroInd(zeroInd), .zeroValid(zeroValid),
        .zeroPosOut(zeroPosOut), .limitHit(limitHit));
    drive_model drv (.sys_clk(sys_clk), .nrst(nrst), .axisMove(axisMove), .moveNeg(moveNeg),
        .velCmd(velCmd), .slowSw(slowSw), .indexPulse(indexPulse),
        .axisStopped(axisStopped), .axisPos(axisPos));

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic testDone;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one idle edge after each transfer keeps back-to-back calls race free
    task automatic apb(input logic [7:0] a, input logic wr, input logic [DW-1:0] w);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= wr; pwdata <= w;
        @(posedge sys_clk);
        penable <= 1;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; testDone(); end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge sys_clk);
        #1;
    endtask
    // kind 0 waits for a velocity, kind 1 for an axis indicator
    task automatic waitFor(input int kind, input int i, input logic [DW-1:0] v);
        int n;
        n = 0;
        while (!(kind == 0 ? velCmd === v : zeroInd[i] === 1'b1) && n < 2000) begin
            @(posedge sys_clk); #1; n++;
        end
        if (n >= 2000) begin errors++; testDone(); end
    endtask

    initial begin
        nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        nvZeroValid = 5'h08; nvZeroPos = '0; nvZeroPos[3] = 32'h0000_0064;
        repeat (16) @(posedge sys_clk);
        nrst <= 1;
        repeat (3) @(posedge sys_clk);
        #1;
        check(DW'(zeroValid), 32'h08);
        check(zeroPosOut[3], 32'h64);
        @(posedge sys_clk);
        foreach (rows[k]) begin
            if (rows[k].wr) apb(rows[k].a, 1'b1, rows[k].w);
            apb(rows[k].a, 1'b0, 32'h0);
            check(rd, rows[k].e);
            check(DW'(er), DW'(rows[k].er));
        end
        // common return with index on axis 0, homing negative
        apb(8'h00, 1'b1, 32'h0000_0105);
        apb(8'h04, 1'b1, 32'h0000_0010);
        check(velCmd, 32'h10);
        check(DW'({moveNeg, axisMove}), 32'h21);
        waitFor(0, 0, 32'h08);
        waitFor(0, 0, 32'h02);
        waitFor(1, 0, '0);
        check(velCmd, 32'h0);
        // high-speed return on axis 1
        apb(8'h00, 1'b1, 32'h0000_0207);
        apb(8'h04, 1'b1, 32'h0000_0011);
        check(velCmd, 32'h10);
        waitFor(0, 1, 32'h08);
        waitFor(0, 1, 32'h03);
        check(DW'(moveNeg), 32'h0);
        waitFor(1, 1, '0);
        // high-speed without index must not start
        apb(8'h00, 1'b1, 32'h0000_0003);
        apb(8'h04, 1'b1, 32'h0000_0012);
        repeat (3) @(posedge sys_clk);
        check(velCmd, 32'h0);
        // multi-turn bit missing: no capture
        apb(8'h00, 1'b1, 32'h0000_0051);
        apb(8'h04, 1'b1, 32'h0000_1000);
        check(DW'(zeroValid[4]), 32'h0);
        apb(8'h00, 1'b1, 32'h0000_0071);
        apb(8'h04, 1'b1, 32'h0000_0400);
        check(DW'(zeroValid[2]), 32'h1);
        check(zeroPosOut[2], axisPos[2]);
        check(DW'(zeroInd[2]), 32'h1);
        // limits on: axes 1 and 4 lie above a zero positive bound
        apb(8'h00, 1'b1, 32'h0000_04F1);
        @(posedge sys_clk);
        #1;
        check(DW'(zeroInd[2]), 32'h0);
        check(DW'(limitHit), 32'h12);
        // operator sets the zero again before any dependent point
        apb(8'h04, 1'b1, 32'h0000_0400);
        check(DW'(zeroInd[2]), 32'h1);
        testDone();
    end
endmodule // tb_top
